/* File: urmc_pkg.sv */
/*
  Shared constants and types of the redriver mode control block.
  Assumes a single 25 MHz clock and a synchronous active-high reset.
*/
package urmc_pkg;

  // Clock rate and derived cycle counts
  localparam int CLK_MHZ        = 25;
  localparam int STRAP_DELAY_US = 1;
  localparam int STRAP_CYC      = STRAP_DELAY_US * CLK_MHZ;
  localparam int READY_MAX_US   = 500;
  localparam int READY_MAX_CYC  = READY_MAX_US * CLK_MHZ;
  localparam int CHIRP_MIN_US   = 18;
  localparam int CHIRP_MAX_US   = 128;
  localparam int CHIRP_MIN_CYC  = CHIRP_MIN_US * CLK_MHZ;
  localparam int CHIRP_MAX_CYC  = CHIRP_MAX_US * CLK_MHZ;

  // Serial target address
  localparam logic [6:0] TARGET_ADDR = 7'h2c;

  // Register offsets
  localparam logic [7:0] OFS_EDGE   = 8'h01;
  localparam logic [7:0] OFS_MODE   = 8'h03;
  localparam logic [7:0] OFS_STATIC = 8'h0e;
  localparam logic [7:0] OFS_RXEQ   = 8'h25;

  // Field positions and reset values
  localparam int         EDGE_LSB   = 4;
  localparam int         CFG_BIT    = 0;
  localparam logic [7:0] MODE_RESET = 8'h01;

  // Strap level to code tables, index is boost level 0..3
  localparam logic [15:0] EDGE_CODES   = 16'ha630;
  localparam logic [15:0] STATIC_CODES = 16'h6220;
  localparam logic [7:0]  RXEQ_LOW     = 8'h00;
  localparam logic [7:0]  RXEQ_MID     = 8'h33;
  localparam logic [7:0]  RXEQ_HIGH    = 8'h66;

  // USB line states from the analog receivers
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J   = 2'h1;
  localparam logic [1:0] LINE_K   = 2'h2;

  // Synchroniser bit positions and reset value
  localparam int          SI_EN    = 0;
  localparam int          SI_SCL   = 1;
  localparam int          SI_SDA   = 2;
  localparam int          SI_CHG   = 3;
  localparam int          SI_RXH   = 4;
  localparam int          SI_RXL   = 5;
  localparam int          SI_BST   = 6;
  localparam int          SI_LINE  = 9;
  localparam int          SI_FIX   = 11;
  localparam int          SI_DISC  = 12;
  localparam int          SI_W     = 13;
  localparam logic [12:0] SI_RESET = 13'h000f;

  typedef enum logic [2:0] {
    MD_SHUTDOWN = 3'b000,
    MD_STRAP    = 3'b001,
    MD_UNCONN   = 3'b010,
    MD_LOW      = 3'b011,
    MD_FULL     = 3'b100,
    MD_HIGH     = 3'b101,
    MD_EYETEST  = 3'b110,
    MD_HOLD     = 3'b111
  } urmc_mode_t;

  typedef enum logic [2:0] {
    IS_IDLE  = 3'b000,
    IS_ADDR  = 3'b001,
    IS_ACKA  = 3'b010,
    IS_WDATA = 3'b011,
    IS_ACKW  = 3'b100,
    IS_RDATA = 3'b101,
    IS_ACKR  = 3'b110
  } urmc_i2c_t;

endpackage

/* File: urmc_cfg_if.sv */
/*
  Link between the serial target and the control core.
  Assumes both ends run on the same clock; bus lines arrive synchronised.
*/
`timescale 1ns/1ps
interface urmc_cfg_if;
  logic       enable;
  logic       scl;
  logic       sda;
  logic       sda_low;
  logic       wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport target (input enable, scl, sda, rdata, output sda_low, wr_stb, addr, wdata);
  modport core   (output enable, scl, sda, rdata, input sda_low, wr_stb, addr, wdata);
endinterface

/* File: urmc_i2c_target.sv */
/*
  Standard-mode serial target: pointer byte, then data writes or reads.
  Assumes scl and sda are already synchronised to the clock.
*/
`timescale 1ns/1ps
module urmc_i2c_target (
  input  wire logic clock,
  input  wire logic srst,
  urmc_cfg_if.target bus
);

  typedef struct packed {
    urmc_pkg::urmc_i2c_t st;
    logic [3:0]          cnt;
    logic [7:0]          sh;
    logic [7:0]          ptr;
    logic                first;
    logic                rw;
    logic                nack;
    logic                sda_lo;
    logic                scl_d;
    logic                sda_d;
    logic                wr;
    logic [7:0]          wd;
  } urmc_i2c_state_t;

  urmc_i2c_state_t s_reg;
  urmc_i2c_state_t s_next;
  logic            rise;
  logic            fall;
  logic            start;
  logic            stop;

  assign rise  = bus.scl & ~s_reg.scl_d;
  assign fall  = ~bus.scl & s_reg.scl_d;
  assign start = bus.scl & s_reg.scl_d & s_reg.sda_d & ~bus.sda;
  assign stop  = bus.scl & s_reg.scl_d & ~s_reg.sda_d & bus.sda;

  always_comb
  begin
    s_next       = s_reg;
    s_next.scl_d = bus.scl;
    s_next.sda_d = bus.sda;
    s_next.wr    = 1'b0;
    if (!bus.enable)
    begin
      s_next.st     = urmc_pkg::IS_IDLE;
      s_next.sda_lo = 1'b0;
    end
    else if (start)
    begin
      s_next.st     = urmc_pkg::IS_ADDR;
      s_next.cnt    = 4'h0;
      s_next.sda_lo = 1'b0;
    end
    else if (stop)
    begin
      s_next.st     = urmc_pkg::IS_IDLE;
      s_next.sda_lo = 1'b0;
    end
    else
    begin
      case (s_reg.st)
        urmc_pkg::IS_ADDR, urmc_pkg::IS_WDATA:
        begin
          if (rise)
          begin
            s_next.sh  = {s_reg.sh[6:0], bus.sda};
            s_next.cnt = s_reg.cnt + 4'h1;
          end
          else if (fall && s_reg.cnt == 4'h8)
          begin
            s_next.sda_lo = 1'b1;
            if (s_reg.st == urmc_pkg::IS_ADDR)
            begin
              if (s_reg.sh[7:1] == urmc_pkg::TARGET_ADDR)
              begin
                s_next.rw    = s_reg.sh[0];
                s_next.first = 1'b1;
                s_next.st    = urmc_pkg::IS_ACKA;
              end
              else
              begin
                s_next.sda_lo = 1'b0;
                s_next.st     = urmc_pkg::IS_IDLE;
              end
            end
            else
            begin
              s_next.st = urmc_pkg::IS_ACKW;
              if (s_reg.first)
              begin
                s_next.ptr   = s_reg.sh;
                s_next.first = 1'b0;
              end
              else
              begin
                s_next.wr = 1'b1;
                s_next.wd = s_reg.sh;
              end
            end
          end
        end
        urmc_pkg::IS_ACKA, urmc_pkg::IS_ACKW:
        begin
          if (fall)
          begin
            s_next.cnt = 4'h0;
            if (s_reg.st == urmc_pkg::IS_ACKA && s_reg.rw)
            begin
              s_next.sh     = bus.rdata;
              s_next.sda_lo = ~bus.rdata[7];
              s_next.st     = urmc_pkg::IS_RDATA;
            end
            else
            begin
              s_next.sda_lo = 1'b0;
              s_next.st     = urmc_pkg::IS_WDATA;
            end
          end
        end
        urmc_pkg::IS_RDATA:
        begin
          if (rise)
            s_next.cnt = s_reg.cnt + 4'h1;
          else if (fall && s_reg.cnt == 4'h8)
          begin
            s_next.sda_lo = 1'b0;
            s_next.st     = urmc_pkg::IS_ACKR;
          end
          else if (fall)
          begin
            s_next.sh     = {s_reg.sh[6:0], 1'b0};
            s_next.sda_lo = ~s_reg.sh[6];
          end
        end
        urmc_pkg::IS_ACKR:
        begin
          if (rise)
            s_next.nack = bus.sda;
          else if (fall && s_reg.nack)
            s_next.st = urmc_pkg::IS_IDLE;
          else if (fall)
          begin
            s_next.cnt    = 4'h0;
            s_next.sh     = bus.rdata;
            s_next.sda_lo = ~bus.rdata[7];
            s_next.st     = urmc_pkg::IS_RDATA;
          end
        end
        default:
          s_next.sda_lo = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_reg       <= '0;
      s_reg.scl_d <= 1'b1;
      s_reg.sda_d <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign bus.sda_low = s_reg.sda_lo;
  assign bus.wr_stb  = s_reg.wr;
  assign bus.addr    = s_reg.ptr;
  assign bus.wdata   = s_reg.wd;

endmodule

/* File: urmc_mode_control.sv */
/*
  Mode control and status of a high-speed USB signal conditioner.
  Assumes analog front-end comparators deliver line state, strap levels
  and fixture or disconnect events; all pins are synchronised here.
*/
`timescale 1ns/1ps

// Function
// - Low speed: compensation off, attach high
// - Full speed: compensation off, attach high
// - High speed: compensation on, both flags high
// - Test fixture: eye test, attach low
// - Enable pulse during high speed: eye test
// - Enable low: shutdown, flags low, no compensation
// - Four boost levels, pin or register
// - Decode boost pulldown into four levels
// - Three-level equalization select, floating is middle
// - Serial target only if both lines high
// - Registers reached at target address 0x2C
// - Charging controller always on, pin picks mode
// - Unconnected port select means charging host
// - Ready within 500 us after enable release
// - Mode bit 0: configuration hold, resets 1
// - Edge gain loads from boost pin codes
// - High speed after valid chirp pair
// - Attach on pull-up, detach on disconnect
module urmc_mode_control (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       device_enable_n,
  input  wire logic [2:0] boost_sense,
  input  wire logic       rx_eq_sense_high,
  input  wire logic       rx_eq_sense_low,
  input  wire logic       charge_port_type_select,
  input  wire logic [1:0] usb_line_state,
  input  wire logic       fixture_detect,
  input  wire logic       disconnect_detect,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            receive_equalization_select_out,
  output logic            receive_equalization_select_oe,
  output logic            attach_detect_flag,
  output logic            high_speed_active_flag,
  output logic            compensation_enable,
  output logic [3:0]      edge_gain,
  output logic [3:0]      static_gain,
  output logic [7:0]      rx_eq_gain,
  output logic            charging_host_port_mode,
  output logic            dedicated_charge_mode,
  output logic            serial_mode
);

  typedef struct packed {
    logic [12:0]          sync1;
    logic [12:0]          sync2;
    urmc_pkg::urmc_mode_t mode;
    logic [11:0]          cnt;
    logic [1:0]           chirp;
    logic                 hs_before_off;
    logic                 i2c_mode;
    logic [7:0]           edge_reg;
    logic [7:0]           mode_reg;
    logic [7:0]           static_reg;
    logic [7:0]           rxeq_reg;
    logic                 cd;
    logic                 hs;
    logic                 comp;
  } urmc_core_state_t;

  urmc_core_state_t s_reg;
  urmc_core_state_t s_next;
  urmc_cfg_if       cfg ();
  logic             en_n;
  logic [1:0]       line;
  logic [1:0]       blvl;
  logic             chirp_ok;
  logic [7:0]       rd_mux;

  // Thermometer of three comparators to boost level
  function automatic logic [1:0] boost_level(input logic [2:0] t);
    if (t[2])
      boost_level = 2'h3;
    else if (t[1])
      boost_level = 2'h2;
    else if (t[0])
      boost_level = 2'h1;
    else
      boost_level = 2'h0;
  endfunction

  // Picks one nibble of a code table by level
  function automatic logic [3:0] pick_code(input logic [15:0] tbl, input logic [1:0] lv);
    pick_code = tbl[{lv, 2'b00} +: 4];
  endfunction

  function automatic logic is_connected(input urmc_pkg::urmc_mode_t m);
    is_connected = (m == urmc_pkg::MD_LOW) || (m == urmc_pkg::MD_FULL)
                   || (m == urmc_pkg::MD_HIGH);
  endfunction

  function automatic logic fixture_hit();
    fixture_hit = s_reg.sync2[urmc_pkg::SI_FIX];
  endfunction

  assign en_n     = s_reg.sync2[urmc_pkg::SI_EN];
  assign line     = s_reg.sync2[urmc_pkg::SI_LINE +: 2];
  assign blvl     = boost_level(s_reg.sync2[urmc_pkg::SI_BST +: 3]);
  assign chirp_ok = (s_reg.cnt >= 12'(urmc_pkg::CHIRP_MIN_CYC))
                    && (s_reg.cnt <= 12'(urmc_pkg::CHIRP_MAX_CYC));

  // Read decode; unlisted offsets read zero
  always_comb
  begin
    case (cfg.addr)
      urmc_pkg::OFS_EDGE:   rd_mux = s_reg.edge_reg;
      urmc_pkg::OFS_MODE:   rd_mux = s_reg.mode_reg;
      urmc_pkg::OFS_STATIC: rd_mux = s_reg.static_reg;
      urmc_pkg::OFS_RXEQ:   rd_mux = s_reg.rxeq_reg;
      default:              rd_mux = 8'h00;
    endcase
  end

  assign cfg.enable = s_reg.i2c_mode && (s_reg.mode != urmc_pkg::MD_SHUTDOWN)
                      && (s_reg.mode != urmc_pkg::MD_STRAP);
  assign cfg.scl    = s_reg.sync2[urmc_pkg::SI_SCL];
  assign cfg.sda    = s_reg.sync2[urmc_pkg::SI_SDA];
  assign cfg.rdata  = rd_mux;

  urmc_i2c_target u_target (
    .clock (clock),
    .srst  (srst),
    .bus   (cfg)
  );

  always_comb
  begin
    s_next       = s_reg;
    s_next.sync1 = {disconnect_detect, fixture_detect, usb_line_state, boost_sense,
                    rx_eq_sense_low, rx_eq_sense_high, charge_port_type_select,
                    sda_in, scl_in, device_enable_n};
    s_next.sync2 = s_reg.sync1;

    // Register writes only in serial mode, listed offsets only
    if (cfg.wr_stb && s_reg.i2c_mode)
    begin
      case (cfg.addr)
        urmc_pkg::OFS_EDGE:   s_next.edge_reg = cfg.wdata;
        urmc_pkg::OFS_MODE:   s_next.mode_reg = cfg.wdata;
        urmc_pkg::OFS_STATIC: s_next.static_reg = cfg.wdata;
        urmc_pkg::OFS_RXEQ:   s_next.rxeq_reg = cfg.wdata;
        default:              s_next.cnt = s_reg.cnt;
      endcase
    end

    if (en_n)
    begin
      s_next.mode = urmc_pkg::MD_SHUTDOWN;
      s_next.cnt  = 12'h000;
    end
    else
    begin
      case (s_reg.mode)
        urmc_pkg::MD_SHUTDOWN:
        begin
          s_next.mode = urmc_pkg::MD_STRAP;
          s_next.cnt  = 12'h000;
        end
        urmc_pkg::MD_STRAP:
        begin
          s_next.cnt = s_reg.cnt + 12'h001;
          if (s_reg.cnt >= 12'(urmc_pkg::STRAP_CYC - 1))
          begin
            s_next.i2c_mode = s_reg.sync2[urmc_pkg::SI_SCL]
                              && s_reg.sync2[urmc_pkg::SI_SDA];
            s_next.edge_reg = {pick_code(urmc_pkg::EDGE_CODES, blvl), 4'h0};
            s_next.static_reg = {4'h0, pick_code(urmc_pkg::STATIC_CODES, blvl)};
            s_next.mode_reg = urmc_pkg::MODE_RESET;
            if (s_reg.sync2[urmc_pkg::SI_RXH])
              s_next.rxeq_reg = urmc_pkg::RXEQ_HIGH;
            else if (s_reg.sync2[urmc_pkg::SI_RXL])
              s_next.rxeq_reg = urmc_pkg::RXEQ_LOW;
            else
              s_next.rxeq_reg = urmc_pkg::RXEQ_MID;
            if (s_reg.hs_before_off)
              s_next.mode = urmc_pkg::MD_EYETEST;
            else
              s_next.mode = urmc_pkg::MD_UNCONN;
          end
        end
        urmc_pkg::MD_HOLD:
        begin
          if (!s_reg.mode_reg[urmc_pkg::CFG_BIT])
            s_next.mode = urmc_pkg::MD_UNCONN;
        end
        urmc_pkg::MD_UNCONN:
        begin
          s_next.hs_before_off = 1'b0;
          s_next.chirp         = 2'h0;
          if (fixture_hit())
            s_next.mode = urmc_pkg::MD_EYETEST;
          else if (line == urmc_pkg::LINE_J)
            s_next.mode = urmc_pkg::MD_FULL;
          else if (line == urmc_pkg::LINE_K)
            s_next.mode = urmc_pkg::MD_LOW;
        end
        urmc_pkg::MD_LOW, urmc_pkg::MD_FULL:
        begin
          if (s_reg.cnt != 12'hfff)
            s_next.cnt = s_reg.cnt + 12'h001;
          case (s_reg.chirp)
            2'h0:
              if (line == urmc_pkg::LINE_SE0)
                s_next.chirp = 2'h1;
            2'h1:
            begin
              s_next.cnt = 12'h000;
              if (line == urmc_pkg::LINE_J)
                s_next.chirp = 2'h2;
            end
            2'h2:
              if (line != urmc_pkg::LINE_J)
              begin
                s_next.cnt   = 12'h000;
                s_next.chirp = (chirp_ok && line == urmc_pkg::LINE_K) ? 2'h3 : 2'h0;
              end
            default:
              if (line != urmc_pkg::LINE_K)
              begin
                s_next.chirp = 2'h0;
                if (chirp_ok)
                  s_next.mode = urmc_pkg::MD_HIGH;
              end
          endcase
          if (s_reg.sync2[urmc_pkg::SI_DISC])
            s_next.mode = urmc_pkg::MD_UNCONN;
        end
        urmc_pkg::MD_HIGH:
        begin
          s_next.hs_before_off = 1'b1;
          if (s_reg.sync2[urmc_pkg::SI_DISC])
            s_next.mode = urmc_pkg::MD_UNCONN;
        end
        urmc_pkg::MD_EYETEST:
        begin
          if (s_reg.sync2[urmc_pkg::SI_DISC])
            s_next.mode = urmc_pkg::MD_UNCONN;
        end
        default:
          s_next.mode = urmc_pkg::MD_SHUTDOWN;
      endcase

      // Hold bit halts the mode machine in serial mode
      if (s_reg.i2c_mode && s_next.mode_reg[urmc_pkg::CFG_BIT]
          && s_reg.mode != urmc_pkg::MD_STRAP)
        s_next.mode = urmc_pkg::MD_HOLD;
    end

    // Status and compensation from the next mode
    s_next.cd   = is_connected(s_next.mode);
    s_next.hs   = (s_next.mode == urmc_pkg::MD_HIGH)
                  || (s_next.mode == urmc_pkg::MD_EYETEST);
    s_next.comp = s_next.hs;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_reg          <= '0;
      s_reg.sync1    <= urmc_pkg::SI_RESET;
      s_reg.sync2    <= urmc_pkg::SI_RESET;
      s_reg.mode_reg <= urmc_pkg::MODE_RESET;
    end
    else
      s_reg <= s_next;
  end

  // Pins double as straps until the mode machine leaves MD_STRAP
  assign attach_detect_flag              = s_reg.cd;
  assign high_speed_active_flag          = s_reg.hs;
  assign compensation_enable             = s_reg.comp;
  assign edge_gain                       = s_reg.edge_reg[urmc_pkg::EDGE_LSB +: 4];
  assign static_gain                     = s_reg.static_reg[3:0];
  assign rx_eq_gain                      = s_reg.rxeq_reg;
  assign scl_out                         = s_reg.cd;
  assign scl_oe                          = !s_reg.i2c_mode
                                           && s_reg.mode != urmc_pkg::MD_SHUTDOWN
                                           && s_reg.mode != urmc_pkg::MD_STRAP;
  assign receive_equalization_select_out = s_reg.hs;
  assign receive_equalization_select_oe  = scl_oe;
  assign sda_out                         = 1'b0;
  assign sda_oe                          = cfg.sda_low;
  assign charging_host_port_mode         = s_reg.sync2[urmc_pkg::SI_CHG];
  assign dedicated_charge_mode           = !s_reg.sync2[urmc_pkg::SI_CHG];
  assign serial_mode                     = s_reg.i2c_mode;

endmodule

/* File: urmc_mode_control_assertions.sv */
/*
  Checker of the mode control status pins.
  Bound to the top module; sees only its ports.
*/
`timescale 1ns/1ps
module urmc_mode_control_chk (
  input wire logic clock,
  input wire logic srst,
  input wire logic device_enable_n,
  input wire logic charge_port_type_select,
  input wire logic disconnect_detect,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic receive_equalization_select_out,
  input wire logic receive_equalization_select_oe,
  input wire logic attach_detect_flag,
  input wire logic high_speed_active_flag,
  input wire logic compensation_enable,
  input wire logic charging_host_port_mode,
  input wire logic dedicated_charge_mode,
  input wire logic serial_mode
);
  wire cd   = attach_detect_flag;
  wire hs   = high_speed_active_flag;
  wire comp = compensation_enable;
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence s_off;
    device_enable_n [*5];
  endsequence
  sequence s_gone;
    disconnect_detect [*4];
  endsequence
  a_shutdown_flags_low: assert property (s_off |=> !cd && !hs && !comp)
    else $error("flags or compensation active in shutdown");
  a_slow_no_comp: assert property (cd && !hs |-> !comp)
    else $error("compensation on in low or full speed");
  a_high_comp_on: assert property (cd && hs |-> comp)
    else $error("compensation off in high speed");
  a_eye_comp_on: assert property (!cd && hs |-> comp)
    else $error("compensation off in eye test");
  a_comp_needs_hs: assert property (comp |-> hs)
    else $error("compensation without high speed flag");
  a_disc_clears_flags: assert property (s_gone |=> !cd && !hs)
    else $error("flags stay after disconnect");
  a_host_mode_pin: assert property (charge_port_type_select [*5] |=>
    charging_host_port_mode && !dedicated_charge_mode)
    else $error("charging host mode not shown");
  a_ded_mode_pin: assert property (!charge_port_type_select [*5] |=>
    dedicated_charge_mode && !charging_host_port_mode)
    else $error("dedicated charge mode not shown");
  a_pins_show_flags: assert property (scl_oe |-> scl_out == cd
    && receive_equalization_select_out == hs)
    else $error("shared pins differ from flags");
  a_serial_pins_off: assert property (serial_mode && $past(serial_mode) |->
    !scl_oe && !receive_equalization_select_oe)
    else $error("shared pins driven in serial mode");
endmodule

bind urmc_mode_control urmc_mode_control_chk u_urmc_mode_control_chk (.clock, .srst,
  .device_enable_n, .charge_port_type_select, .disconnect_detect, .scl_out, .scl_oe,
  .receive_equalization_select_out, .receive_equalization_select_oe, .attach_detect_flag,
  .high_speed_active_flag, .compensation_enable, .charging_host_port_mode,
  .dedicated_charge_mode, .serial_mode);

/* File: urmc_usb_peer.sv */
/*
  Far-end USB model: line state, fixture and disconnect events.
  Assumes the caller's clock; lines idle at SE0 through pulldowns.
*/
`timescale 1ns/1ps
module urmc_usb_peer (
  input  wire logic clock,
  output logic [1:0] usb_line_state,
  output logic       fixture_detect,
  output logic       disconnect_detect
);
  initial
  begin
    usb_line_state = 2'h0;
    fixture_detect = 1'b0;
    disconnect_detect = 1'b0;
  end
  task automatic hold(input logic [1:0] s, input int n);
    usb_line_state = s;
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic plug(input logic [1:0] s);
    disconnect_detect = 1'b0;
    hold(s, 10);
  endtask
  task automatic unplug();
    disconnect_detect = 1'b1;
    hold(2'h0, 10);
    disconnect_detect = 1'b0;
    hold(2'h0, 2);
  endtask
  // Bus reset, then one chirp J and chirp K pair
  task automatic chirp();
    hold(2'h0, 50);
    hold(2'h1, 600);
    hold(2'h2, 600);
    hold(2'h0, 10);
  endtask
  task automatic fixture();
    fixture_detect = 1'b1;
    hold(2'h0, 10);
    fixture_detect = 1'b0;
  endtask
endmodule

/* File: urmc_mode_control_tb_top.sv */
/*
  Testbench of the redriver mode control block.
  Drives pins and the serial bus; USB far end is a separate model.
*/
`timescale 1ns/1ps
module urmc_mode_control_tb_top;
  localparam int HB = 125;
  logic       clock;
  logic       srst;
  logic       device_enable_n;
  logic [2:0] boost_sense;
  logic       rx_hi;
  logic       rx_lo;
  logic       chg_sel;
  logic       scl_drv;
  logic       sda_drv;
  logic [1:0] line;
  logic       fix;
  logic       disc;
  logic       scl_out;
  logic       scl_oe;
  logic       sda_oe;
  logic       rx_o;
  logic       rx_oe;
  logic       cd;
  logic       hs;
  logic       comp;
  logic [3:0] edge_g;
  logic [3:0] stat_g;
  logic [7:0] eq_g;
  logic       host_m;
  logic       ded_m;
  logic       ser;
  logic [8:0] rd;
  int         fails;
  int         total_checks;
  wire        scl_line = scl_oe ? scl_out : scl_drv;
  wire        sda_line = sda_drv & ~sda_oe;

  urmc_usb_peer u_urmc_usb_peer (.clock(clock), .usb_line_state(line),
    .fixture_detect(fix), .disconnect_detect(disc));
  urmc_mode_control u_urmc_mode_control (.clock(clock), .srst(srst),
    .device_enable_n(device_enable_n), .boost_sense(boost_sense),
    .rx_eq_sense_high(rx_hi), .rx_eq_sense_low(rx_lo),
    .charge_port_type_select(chg_sel), .usb_line_state(line), .fixture_detect(fix),
    .disconnect_detect(disc), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
    .receive_equalization_select_out(rx_o), .receive_equalization_select_oe(rx_oe),
    .attach_detect_flag(cd), .high_speed_active_flag(hs), .compensation_enable(comp),
    .edge_gain(edge_g), .static_gain(stat_g), .rx_eq_gain(eq_g),
    .charging_host_port_mode(host_m), .dedicated_charge_mode(ded_m), .serial_mode(ser));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic st(input logic [2:0] e);
    check("attach hs comp", {5'h0, cd, hs, comp}, {5'h0, e});
  endtask
  task automatic restart(input logic srl);
    int n;
    device_enable_n = 1'b1;
    step(2500);
    st(3'h0);
    device_enable_n = 1'b0;
    n = 0;
    while ((srl ? ser : scl_oe) !== 1'b1 && n < 12500)
    begin
      step(1);
      n++;
    end
    step(40);
    check("ready", {7'h0, srl ? ser : scl_oe}, 8'h01);
  endtask
  task automatic i2c_start();
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    step(HB);
    sda_drv = 1'b0;
    step(HB);
    scl_drv = 1'b0;
  endtask
  task automatic i2c_stop();
    sda_drv = 1'b0;
    step(HB);
    scl_drv = 1'b1;
    step(HB);
    sda_drv = 1'b1;
    step(HB);
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--)
    begin
      sda_drv = (i < 0) ? 1'b1 : b[i];
      step(HB);
      scl_drv = 1'b1;
      step(HB);
      ack = sda_line;
      rd = {rd[7:0], ack};
      scl_drv = 1'b0;
    end
  endtask

  task automatic t_straps();
    logic [3:0] eg [4] = '{4'h0, 4'h3, 4'h6, 4'ha};
    logic [3:0] sg [4] = '{4'h0, 4'h2, 4'h2, 4'h6};
    logic [7:0] qg [4] = '{8'h00, 8'h33, 8'h66, 8'h00};
    logic [2:0] bs [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    for (int i = 0; i < 4; i++)
    begin
      boost_sense = bs[i];
      rx_hi = (i == 2);
      rx_lo = (i == 0 || i == 3);
      restart(1'b0);
      check("edge gain", {4'h0, edge_g}, {4'h0, eg[i]});
      check("static gain", {4'h0, stat_g}, {4'h0, sg[i]});
      check("eq gain", eq_g, qg[i]);
    end
    $display("straps test done");
  endtask
  task automatic t_speeds();
    u_urmc_usb_peer.plug(2'h1);
    st(3'h4);
    check("attach pin", {7'h0, scl_line}, 8'h01);
    u_urmc_usb_peer.unplug();
    st(3'h0);
    u_urmc_usb_peer.plug(2'h2);
    st(3'h4);
    u_urmc_usb_peer.chirp();
    st(3'h7);
    check("hs pin", {6'h0, rx_oe, rx_o}, 8'h03);
    restart(1'b0);
    st(3'h3);
    u_urmc_usb_peer.unplug();
    u_urmc_usb_peer.fixture();
    st(3'h3);
    u_urmc_usb_peer.unplug();
    $display("speeds test done");
  endtask
  task automatic t_charge();
    chg_sel = 1'b0;
    step(6);
    check("charge mode", {6'h0, host_m, ded_m}, 8'h01);
    chg_sel = 1'b1;
    step(6);
    check("charge mode", {6'h0, host_m, ded_m}, 8'h02);
    $display("charge test done");
  endtask
  task automatic t_serial();
    logic a;
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    restart(1'b1);
    check("serial mode", {7'h0, ser}, 8'h01);
    u_urmc_usb_peer.plug(2'h1);
    st(3'h0);
    i2c_start();
    i2c_byte({7'h2d, 1'b0}, a);
    i2c_stop();
    check("wrong address ack", {7'h0, a}, 8'h01);
    i2c_start();
    i2c_byte({7'h2c, 1'b0}, a);
    i2c_byte(8'h01, a);
    i2c_byte(8'h50, a);
    i2c_stop();
    check("edge write", {4'h0, edge_g}, 8'h05);
    i2c_start();
    i2c_byte({7'h2c, 1'b1}, a);
    i2c_byte(8'hff, a);
    i2c_stop();
    check("edge read", rd[8:1], 8'h50);
    i2c_start();
    i2c_byte({7'h2c, 1'b0}, a);
    check("address ack", {7'h0, a}, 8'h00);
    i2c_byte(8'h03, a);
    i2c_byte(8'h00, a);
    check("data ack", {7'h0, a}, 8'h00);
    i2c_stop();
    step(10);
    st(3'h4);
    u_urmc_usb_peer.unplug();
    $display("serial test done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    step(90000);
    fails++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial
  begin
    srst = 1'b1;
    device_enable_n = 1'b1;
    boost_sense = 3'h0;
    rx_hi = 1'b0;
    rx_lo = 1'b0;
    chg_sel = 1'b1;
    scl_drv = 1'b0;
    sda_drv = 1'b0;
    fails = 0;
    total_checks = 0;
    step(10);
    srst = 1'b0;
    step(7500);
    t_straps();
    t_speeds();
    t_charge();
    t_serial();
    tally_and_finish();
  end
endmodule
